// ### rtl/pllc_clock_config.sv
`timescale 1ns/1ps
module pllc_clock_config (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                reference_clock_in,
    output logic                     divided_ref_tick,
    output pllc_pkg::pllc_cfg_t      clock_control_register,
    output logic                     config_ok
);
    import pllc_pkg::*;

    pllc_cfg_t   ctrl_reg;
    logic [31:0] ref_khz_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        ref_d_reg;
    logic [DIV_W-1:0] ref_cnt_reg;
    logic [DIV_W-1:0] ref_cnt_next;
    logic        tick_reg;
    logic        ok_reg;
    pllc_freq_t  freq;

    // bus decode
    wire         setup_phase  = psel & ~penable;
    wire         access_done  = psel & penable & pready_reg;
    wire         wr_en        = access_done & pwrite;
    wire         hit_ctrl     = (paddr == OFS_CTRL);
    wire         hit_ref      = (paddr == OFS_REF);
    wire         hit_dref     = (paddr == OFS_DREF);
    wire         hit_loop     = (paddr == OFS_LOOP);
    wire         hit_vco      = (paddr == OFS_VCO);
    wire         hit_core     = (paddr == OFS_CORE);
    wire         hit_external_clock_out     = (paddr == OFS_EXTERNAL_CLOCK_OUT);
    wire         hit_status   = (paddr == OFS_STATUS);
    wire         mapped       = hit_ctrl | hit_ref | hit_dref | hit_loop | hit_vco
                                | hit_core | hit_external_clock_out | hit_status;
    wire         ro_write     = pwrite & (hit_dref | hit_loop | hit_vco | hit_core
                                | hit_external_clock_out | hit_status);
    wire         bad_access   = ~mapped | ro_write;

    // limit monitors
    wire [31:0]  ratio_n      = 32'(ctrl_reg.pll_input_divider) + 32'd1;
    wire [31:0]  ref_lo_khz   = 32'(64'(DREF_MIN_KHZ) * 64'(ratio_n));
    wire [31:0]  ref_hi_n_khz = 32'(64'(DREF_MAX_KHZ) * 64'(ratio_n));
    wire [31:0]  ref_hi_khz   = (ref_hi_n_khz < REF_MAX_KHZ) ? ref_hi_n_khz : REF_MAX_KHZ;
    logic [ST_W-1:0] status;

    always_comb begin
        status = '0;
        status[ST_DREF] = (freq.dref_khz < DREF_MIN_KHZ) | (freq.dref_khz > DREF_MAX_KHZ);
        status[ST_LOOP] = (freq.loop_khz < LOOP_MIN_KHZ) | (freq.loop_khz > LOOP_MAX_KHZ);
        status[ST_REF]  = (ref_khz_reg < ref_lo_khz) | (ref_khz_reg > ref_hi_khz);
        status[ST_DIV]  = (ctrl_reg.pll_input_divider > DIV_CODE_MAX);
        status[ST_CORE] = (freq.core_khz > CORE_MAX_KHZ);
        status[ST_EXTERNAL_CLOCK_OUT] = (freq.external_clock_out_khz > EXTERNAL_CLOCK_OUT_MAX_KHZ);
        status[ST_SRC]  = (ctrl_reg.core_clock_source_select == SRC_RSVD);
        status[ST_OK]   = ~(|status[ST_SRC:ST_DREF]);
    end

    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = 32'(ctrl_reg);
        end else if (hit_ref) begin
            rd_mux = ref_khz_reg;
        end else if (hit_dref) begin
            rd_mux = freq.dref_khz;
        end else if (hit_loop) begin
            rd_mux = freq.loop_khz;
        end else if (hit_vco) begin
            rd_mux = freq.vco_khz;
        end else if (hit_core) begin
            rd_mux = freq.core_khz;
        end else if (hit_external_clock_out) begin
            rd_mux = freq.external_clock_out_khz;
        end else if (hit_status) begin
            rd_mux = 32'(status);
        end
    end

    // apb answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else if (setup_phase) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= bad_access;
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // software writable fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= CFG_RST;
            ref_khz_reg <= REF_KHZ_RST;
        end else if (wr_en && hit_ctrl) begin
            ctrl_reg    <= pllc_cfg_t'(pwdata[$bits(pllc_cfg_t)-1:0]);
        end else if (wr_en && hit_ref) begin
            ref_khz_reg <= pwdata;
        end
    end

    wire ref_rise = reference_clock_in & ~ref_d_reg;
    always_comb begin
        ref_cnt_next = ref_cnt_reg;
        if (ref_rise) begin
            ref_cnt_next = (ref_cnt_reg >= ctrl_reg.pll_input_divider) ? '0
                           : ref_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_d_reg   <= 1'b0;
            ref_cnt_reg <= '0;
            tick_reg    <= 1'b0;
            ok_reg      <= 1'b0;
        end else begin
            ref_d_reg   <= reference_clock_in;
            ref_cnt_reg <= ref_cnt_next;
            tick_reg    <= ref_rise & (ref_cnt_reg >= ctrl_reg.pll_input_divider);
            ok_reg      <= status[ST_OK];
        end
    end

    pllc_freq_calc u_calc (
        .pclk    (pclk),
        .presetn (presetn),
        .cfg     (ctrl_reg),
        .ref_khz (ref_khz_reg),
        .freq    (freq)
    );

    assign prdata                 = prdata_reg;
    assign pready                 = pready_reg;
    assign pslverr                = pslverr_reg;
    assign divided_ref_tick       = tick_reg;
    assign clock_control_register = ctrl_reg;
    assign config_ok              = ok_reg;

endmodule

// ### rtl/pllc_pkg.sv
// Behaviour
// - the input divider divides the reference by the divider field plus one, codes 0x00 to 0x09 giving 1 to 10.
// - the multiplier stage multiplies the divided reference by the multiplier field plus one to give the loop frequency.
// - the vco frequency is the loop frequency when the range bit is 1 and half of it when the bit is 0.
// - the core clock source is the undivided reference, the vco frequency or the vco frequency halved.
// - selector code 11 passes the vco undivided and code 01 halves it, for overall division 1, 2 or 4.
package pllc_pkg;

    localparam int DIV_W  = 4;
    localparam int MULT_W = 6;
    localparam int EXTERNAL_CLOCK_OUT_W = 3;

    typedef enum logic [1:0] {
        SRC_REF      = 2'b00,
        SRC_VCO_HALF = 2'b01,
        SRC_RSVD     = 2'b10,
        SRC_VCO      = 2'b11
    } pllc_src_t;

    typedef struct packed {
        logic [EXTERNAL_CLOCK_OUT_W-1:0] external_clock_out_div;
        pllc_src_t         core_clock_source_select;
        logic              vco_range_select;
        logic [MULT_W-1:0] pll_loop_multiplier;
        logic [DIV_W-1:0]  pll_input_divider;
    } pllc_cfg_t;

    typedef struct packed {
        logic [31:0] dref_khz;
        logic [31:0] loop_khz;
        logic [31:0] vco_khz;
        logic [31:0] core_khz;
        logic [31:0] external_clock_out_khz;
    } pllc_freq_t;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_REF    = 8'h04;
    localparam logic [7:0] OFS_DREF   = 8'h08;
    localparam logic [7:0] OFS_LOOP   = 8'h0c;
    localparam logic [7:0] OFS_VCO    = 8'h10;
    localparam logic [7:0] OFS_CORE   = 8'h14;
    localparam logic [7:0] OFS_EXTERNAL_CLOCK_OUT   = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;

    // reset values
    localparam pllc_cfg_t   CFG_RST     = '{external_clock_out_div: 3'h3, core_clock_source_select: SRC_REF,
                                            vco_range_select: 1'b1, pll_loop_multiplier: 6'h0,
                                            pll_input_divider: 4'h0};
    localparam logic [31:0] REF_KHZ_RST = 32'h0000_61a8;

    // limits in kHz
    localparam logic [31:0] DREF_MIN_KHZ = 32'd10000;
    localparam logic [31:0] DREF_MAX_KHZ = 32'd25000;
    localparam logic [31:0] LOOP_MIN_KHZ = 32'd266000;
    localparam logic [31:0] LOOP_MAX_KHZ = 32'd532000;
    localparam logic [31:0] REF_MAX_KHZ  = 32'd100000;
    localparam logic [31:0] CORE_MAX_KHZ = 32'd300000;
    localparam logic [31:0] EXTERNAL_CLOCK_OUT_MAX_KHZ = 32'd75000;
    localparam logic [DIV_W-1:0] DIV_CODE_MAX = 4'h9;

    // status bit positions
    localparam int ST_DREF = 0;
    localparam int ST_LOOP = 1;
    localparam int ST_REF  = 2;
    localparam int ST_DIV  = 3;
    localparam int ST_CORE = 4;
    localparam int ST_EXTERNAL_CLOCK_OUT = 5;
    localparam int ST_SRC  = 6;
    localparam int ST_OK   = 7;
    localparam int ST_W    = 8;

endpackage

// ### rtl/pllc_freq_calc.sv
`timescale 1ns/1ps
module pllc_freq_calc (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire pllc_pkg::pllc_cfg_t cfg,
    input  wire logic [31:0]         ref_khz,
    output pllc_pkg::pllc_freq_t     freq
);
    import pllc_pkg::*;

    pllc_freq_t freq_reg;
    pllc_freq_t freq_next;
    logic [31:0] div_ratio;
    logic [31:0] mult_ratio;
    logic [63:0] loop_full;
    logic [31:0] core_sel;
    logic [31:0] external_clock_out_ratio;

    assign div_ratio  = 32'(cfg.pll_input_divider) + 32'd1;
    assign mult_ratio = 32'(cfg.pll_loop_multiplier) + 32'd1;
    assign loop_full  = 64'(freq_reg.dref_khz) * 64'(mult_ratio);
    assign external_clock_out_ratio = 32'(cfg.external_clock_out_div) + 32'd1;

    always_comb begin
        unique case (cfg.core_clock_source_select)
            SRC_VCO:      core_sel = freq_reg.vco_khz;
            SRC_VCO_HALF: core_sel = freq_reg.vco_khz >> 1;
            default:      core_sel = ref_khz;
        endcase
    end

    always_comb begin
        freq_next = freq_reg;
        freq_next.dref_khz = ref_khz / div_ratio;
        freq_next.loop_khz = loop_full[31:0];
        freq_next.vco_khz  = cfg.vco_range_select ? freq_reg.loop_khz : (freq_reg.loop_khz >> 1);
        freq_next.core_khz = core_sel;
        freq_next.external_clock_out_khz = freq_reg.core_khz / external_clock_out_ratio;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_reg <= '0;
        end else begin
            freq_reg <= freq_next;
        end
    end

    assign freq = freq_reg;

endmodule

// ### bench/pllc_ref_model.sv
`timescale 1ns/1ps
module pllc_ref_model #(
    parameter real HALF_NS = 20.0
) (
    output logic reference_clock_in
);
    initial begin
        reference_clock_in = 1'b0;
        #3.1;
        forever #HALF_NS reference_clock_in = ~reference_clock_in;
    end
endmodule

// ### bench/pllc_clock_config_asserts.sv
`timescale 1ns/1ps
module pllc_clock_config_asserts
    import pllc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        reference_clock_in,
    input wire logic        divided_ref_tick,
    input wire pllc_cfg_t   clock_control_register,
    input wire logic        config_ok
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_acc; psel && penable && pready; endsequence
    a_ready_next: assert property (s_setup |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
        else $error("answer without select");
    a_unmapped_err: assert property (s_acc ##0 (paddr > OFS_STATUS) |-> pslverr)
        else $error("unmapped without error");
    a_ro_write_err: assert property (s_acc ##0 (pwrite && paddr >= OFS_DREF) |-> pslverr)
        else $error("read-only write accepted");
    a_cfg_store: assert property (
        s_acc ##0 (pwrite && paddr == OFS_CTRL) |=> clock_control_register == $past(pwdata[15:0]))
        else $error("control field not stored");
    a_tick_pulse: assert property (divided_ref_tick |=> !divided_ref_tick)
        else $error("tick too long");
    a_rsvd_flag: assert property (
        (clock_control_register.core_clock_source_select == SRC_RSVD) [*7] |-> !config_ok)
        else $error("reserved source not flagged");
    a_div_flag: assert property (
        (clock_control_register.pll_input_divider > DIV_CODE_MAX) [*7] |-> !config_ok)
        else $error("divider code not flagged");
endmodule
bind pllc_clock_config pllc_clock_config_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_clock_in(reference_clock_in), .divided_ref_tick(divided_ref_tick),
    .clock_control_register(clock_control_register), .config_ok(config_ok));

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pllc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, r, dref, loopf, vco, core, external_clock_out, hi, st;
    logic        pready, pslverr, ref_clk, tick, ok;
    pllc_cfg_t   ctrl, c;
    logic [64:0] notes[$];
    logic [64:0] nt;
    int          fails = 0, check_count = 0, cyc = 0, ticks;
    always #2.5 pclk = ~pclk;
    pllc_ref_model u_ref (.reference_clock_in(ref_clk));
    pllc_clock_config u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reference_clock_in(ref_clk), .divided_ref_tick(tick),
        .clock_control_register(ctrl), .config_ok(ok));
    task close_out;
        $display("checks %0d errors %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e, input logic err);
        notes.push_back({err, m, e});
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (!pready);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    always @(posedge pclk) if (psel && penable && pready) begin
        nt = notes.pop_front();
        check_count++;
        if ((prdata & nt[63:32]) !== nt[31:0] || pslverr !== nt[64]) begin
            fails++;
            $display("ERROR apb %h expected %h/%b seen %h/%b", paddr, nt[31:0], nt[64],
                     prdata & nt[63:32], pslverr);
        end
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin fails++; close_out; end
    end
    initial begin
        void'($urandom(32'h8122bafd));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, OFS_CTRL, 0, '1, {16'h0, CFG_RST}, 0);
        apb(0, OFS_REF, 0, '1, REF_KHZ_RST, 0);
        apb(0, 8'h40, 0, '1, 0, 1);
        apb(1, OFS_CORE, 32'h1, 0, 0, 1);
        for (int i = 0; i < 8; i++) begin
            c.pll_input_divider = (i == 7) ? 4'hc : 4'($urandom % 10);
            c.pll_loop_multiplier = 6'($urandom % 64);
            c.vco_range_select = i[2];
            c.core_clock_source_select = pllc_src_t'(i[1:0]);
            c.external_clock_out_div = 3'($urandom % 8);
            r = 10000 + $urandom % 90001;
            apb(1, OFS_REF, r, 0, 0, 0);
            apb(1, OFS_CTRL, {16'h0, c}, 0, 0, 0);
            repeat (8) @(posedge pclk);
            dref = r / (c.pll_input_divider + 1);
            loopf = dref * (c.pll_loop_multiplier + 1);
            vco = c.vco_range_select ? loopf : loopf >> 1;
            core = (c.core_clock_source_select == SRC_VCO) ? vco :
                   (c.core_clock_source_select == SRC_VCO_HALF) ? vco >> 1 : r;
            apb(0, OFS_DREF, 0, '1, dref, 0);
            apb(0, OFS_LOOP, 0, '1, loopf, 0);
            apb(0, OFS_VCO, 0, '1, vco, 0);
            external_clock_out = core / (c.external_clock_out_div + 1);
            hi = DREF_MAX_KHZ * (c.pll_input_divider + 1);
            if (hi > REF_MAX_KHZ) hi = REF_MAX_KHZ;
            st = 32'h0000_0000;
            st[ST_DREF] = (dref < DREF_MIN_KHZ) || (dref > DREF_MAX_KHZ);
            st[ST_LOOP] = (loopf < LOOP_MIN_KHZ) || (loopf > LOOP_MAX_KHZ);
            st[ST_REF]  = (r < DREF_MIN_KHZ * (c.pll_input_divider + 1)) || (r > hi);
            st[ST_DIV]  = c.pll_input_divider > DIV_CODE_MAX;
            st[ST_CORE] = core > CORE_MAX_KHZ;
            st[ST_EXTERNAL_CLOCK_OUT] = external_clock_out > EXTERNAL_CLOCK_OUT_MAX_KHZ;
            st[ST_SRC]  = c.core_clock_source_select == SRC_RSVD;
            st[ST_OK]   = ~(|st[ST_SRC:ST_DREF]);
            apb(0, OFS_CORE, 0, '1, core, 0);
            apb(0, OFS_EXTERNAL_CLOCK_OUT, 0, '1, external_clock_out, 0);
            apb(0, OFS_STATUS, 0, 32'hff, st, 0);
            check_count++;
            if (ok !== st[ST_OK]) begin
                fails++;
                $display("ERROR config_ok expected %b seen %b", st[ST_OK], ok);
            end
            check_count++;
            if (ctrl !== c) begin
                fails++;
                $display("ERROR clock_control_register expected %h seen %h", c, ctrl);
            end
        end
        for (int k = 0; k < 2; k++) begin
            c.pll_input_divider = 4'(k * 9);
            apb(1, OFS_CTRL, {16'h0, c}, 0, 0, 0);
            ticks = 0;
            repeat (80 * (k * 9 + 1)) begin
                @(posedge pclk);
                if (tick === 1'b1) ticks++;
            end
            check_count++;
            if (ticks < 9 || ticks > 11) begin
                fails++;
                $display("ERROR tick count expected 10 seen %0d", ticks);
            end
        end
        if (notes.size() != 0) fails++;
        close_out;
    end
endmodule
